// ==== hdl/i2ctis_top.sv ====
// top of the target interrupt and status block
// assumes: a shift engine outside reports bus events as one-cycle pulses
//
// What this block does
// - clearing the last pending enabled source drops the interrupt output
// - clear register clears only bits written one
// - only enabled sources reach the interrupt
// - stop, start, data sources, one bit each
// - global enable gates the whole interrupt
// - raw or masked status readable, selectable
// - one-bit summary of raw or masked status
// - action code: idle, wrote, reads, first byte
// - data register holds received, sends written bytes
// - bus address compared with own addresses
`timescale 1ns/1ps
module i2ctis_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [i2ctis_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [i2ctis_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [i2ctis_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  output logic                            wb_err_o,
  input  wire logic                       bus_start_i,
  input  wire logic                       bus_stop_i,
  input  wire logic                       addr_valid_i,
  input  wire logic [6:0]                 addr_byte_i,
  input  wire logic                       addr_rnw_i,
  input  wire logic                       rx_valid_i,
  input  wire logic [7:0]                 rx_byte_i,
  input  wire logic                       tx_taken_i,
  output logic      [7:0]                 tx_byte_o,
  output logic                            addr_match_o,
  output logic                            irq_o
);
  import i2ctis_pkg::*;

  // ************************************************************
  // bus slave
  // ************************************************************
  logic [DATA_W-1:0]      ctrl_ff;
  logic [DATA_W-1:0]      ownaddr_ff;
  logic [NSRC-1:0]        imask_ff;
  logic [NSRC-1:0]        raw_ff;
  logic [NSRC-1:0]        nxt_raw;
  logic [7:0]             rx_ff;
  logic [7:0]             tx_ff;
  i2ctis_action_type      action_ff;
  logic                   sec_ff;
  logic                   first_ff;
  logic                   ack_ff;
  logic                   err_ff;
  logic [DATA_W-1:0]      rdat_ff;
  logic                   req;
  logic                   wr;
  logic                   rd;
  logic                   mapped;
  logic [DATA_W-1:0]      wmask;
  logic [NSRC-1:0]        events;
  logic [NSRC-1:0]        masked;
  logic [NSRC-1:0]        clr_bits;
  logic                   hit1;
  logic                   hit2;
  logic [DATA_W-1:0]      rdata;

  // one access per request; ack drops the cycle after it rose
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign wr  = req & wb_we_i & mapped;
  assign rd  = req & ~wb_we_i & mapped;

  always_comb begin
    mapped = 1'b1;
    unique case (wb_adr_i)
      OFS_CTRL, OFS_OWNADDR, OFS_DATA, OFS_ACTION, OFS_IMASK,
      OFS_RAWST, OFS_MSKST, OFS_ICLR, OFS_SUMST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= req & mapped;
      err_ff <= req & ~mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff    <= CTRL_RST;
      ownaddr_ff <= OWNADDR_RST;
      imask_ff   <= IMASK_RST;
    end else if (wr) begin
      if (wb_adr_i == OFS_CTRL)
        ctrl_ff <= (ctrl_ff & ~wmask) | (wb_dat_i & wmask);
      if (wb_adr_i == OFS_OWNADDR)
        ownaddr_ff <= (ownaddr_ff & ~wmask) | (wb_dat_i & wmask);
      if (wb_adr_i == OFS_IMASK && wb_sel_i[0])
        imask_ff <= wb_dat_i[NSRC-1:0];
    end
  end

  // ************************************************************
  // address match and action state
  // ************************************************************
  // own addresses are compared only while the target is enabled
  assign hit1 = ctrl_ff[CTRL_ENABLE] &
                (addr_byte_i == ownaddr_ff[OWN1_LSB +: 7]);
  assign hit2 = ctrl_ff[CTRL_ENABLE] & ownaddr_ff[OWN2_EN] &
                (addr_byte_i == ownaddr_ff[OWN2_LSB +: 7]);
  assign addr_match_o = addr_valid_i & (hit1 | hit2);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      action_ff <= ACTION_IDLE;
      sec_ff    <= 1'b0;
      first_ff  <= 1'b0;
    end else begin
      if (addr_match_o) begin
        sec_ff   <= ~hit1;
        first_ff <= ~addr_rnw_i;
        action_ff <= addr_rnw_i ? ACTION_MASTER_READS : ACTION_IDLE;
      end else if (rx_valid_i) begin
        action_ff <= first_ff ? ACTION_FIRST_BYTE_IN
                              : ACTION_MASTER_WROTE;
        first_ff  <= 1'b0;
      end else if (tx_taken_i && action_ff == ACTION_MASTER_READS) begin
        action_ff <= ACTION_MASTER_READS;
      end else if (rd && wb_adr_i == OFS_DATA) begin
        action_ff <= ACTION_IDLE;
      end else if (bus_stop_i) begin
        action_ff <= ACTION_IDLE;
      end
    end
  end

  // ************************************************************
  // data register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
    end else begin
      if (rx_valid_i)
        rx_ff <= rx_byte_i;
      if (wr && wb_adr_i == OFS_DATA && wb_sel_i[0])
        tx_ff <= wb_dat_i[7:0];
    end
  end
  assign tx_byte_o = tx_ff;

  // ************************************************************
  // interrupt sources
  // ************************************************************
  always_comb begin
    events = '0;
    events[SRC_DATA]  = rx_valid_i | (tx_taken_i | addr_match_o & addr_rnw_i);
    events[SRC_START] = bus_start_i;
    events[SRC_STOP]  = bus_stop_i;
  end

  // a raw or masked status read also clears all bits (a summary read does not), like an explicit clear write
  always_comb begin
    clr_bits = '0;
    if (wr && wb_adr_i == OFS_ICLR && wb_sel_i[0])
      clr_bits = wb_dat_i[NSRC-1:0];
    if (rd && (wb_adr_i == OFS_RAWST || wb_adr_i == OFS_MSKST))
      clr_bits = '1;
  end

  // set beats clear so an event in the clearing cycle survives
  assign nxt_raw = (raw_ff & ~clr_bits) | events;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      raw_ff <= '0;
    else
      raw_ff <= nxt_raw;
  end

  assign masked = raw_ff & imask_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= ctrl_ff[CTRL_IRQ_EN] & |(nxt_raw & imask_ff);
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_comb begin
    rdata = '0;
    unique case (wb_adr_i)
      OFS_CTRL:    rdata = ctrl_ff;
      OFS_OWNADDR: rdata = ownaddr_ff;
      OFS_DATA:    rdata[7:0] = rx_ff;
      OFS_ACTION:  rdata = {27'h0, sec_ff, 2'h0, action_ff};
      OFS_IMASK:   rdata[NSRC-1:0] = imask_ff;
      OFS_RAWST:   rdata[NSRC-1:0] = raw_ff;
      OFS_MSKST:   rdata[NSRC-1:0] = masked;
      OFS_SUMST:   rdata[0] = ctrl_ff[CTRL_MASKSEL] ? |masked
                                                    : |raw_ff;
      default:     rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      rdat_ff <= '0;
    else if (rd)
      rdat_ff <= rdata;
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;

endmodule

// ==== common/i2ctis_pkg.sv ====
// package: register map, field layout and codes of the target irq/status block
// assumes: classic wishbone, 32-bit data, byte addresses, word aligned
package i2ctis_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NSRC   = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OWNADDR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ACTION  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IMASK   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RAWST   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MSKST   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ICLR    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SUMST   = 8'h20;

  // source bit positions, shared by mask, status and clear
  localparam int unsigned SRC_DATA  = 0;
  localparam int unsigned SRC_START = 1;
  localparam int unsigned SRC_STOP  = 2;

  // control register fields
  localparam int unsigned CTRL_ENABLE  = 0;
  localparam int unsigned CTRL_IRQ_EN  = 1;
  localparam int unsigned CTRL_MASKSEL = 2;

  // own address register fields
  localparam int unsigned OWN1_LSB = 0;
  localparam int unsigned OWN2_LSB = 8;
  localparam int unsigned OWN2_EN  = 15;

  // action register fields
  localparam int unsigned ACT_SEC_BIT = 4;

  localparam logic [DATA_W-1:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] OWNADDR_RST = 32'h0000_0000;
  localparam logic [NSRC-1:0]   IMASK_RST   = 3'h0;

  typedef enum logic [1:0] {
    ACTION_IDLE          = 2'b00,
    ACTION_MASTER_WROTE  = 2'b01,
    ACTION_MASTER_READS  = 2'b10,
    ACTION_FIRST_BYTE_IN = 2'b11
  } i2ctis_action_type;

endpackage

// ==== bench/i2ctis_checker.sv ====
// checker: bus answer and interrupt timing at the block pins
// assumes: bound into i2ctis_top, one clock, reset held 2+ edges
`timescale 1ns/1ps
// ********
// checks
// ********
module i2ctis_checker
  import i2ctis_pkg::*;
(
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_we_i,
  input wire logic [i2ctis_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [i2ctis_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic                          wb_ack_o,
  input wire logic                          wb_err_o,
  input wire logic                          bus_start_i,
  input wire logic                          bus_stop_i,
  input wire logic                          addr_valid_i,
  input wire logic                          rx_valid_i,
  input wire logic                          tx_taken_i,
  input wire logic [7:0]                    tx_byte_o,
  input wire logic                          addr_match_o,
  input wire logic                          irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic evt;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign evt = bus_start_i | bus_stop_i | addr_valid_i | rx_valid_i;
  sequence taken_s; req; endsequence
  sequence answer_s; wb_ack_o ^ wb_err_o; endsequence
  answer_lat_a: assert property (taken_s |=> answer_s)
    else $error("no single answer one cycle after a request");
  ack_pulse_a: assert property ((wb_ack_o | wb_err_o) |->
    $past(req) ##1 !(wb_ack_o | wb_err_o))
    else $error("answer without request or longer than one cycle");
  err_map_a: assert property (wb_err_o |->
    $past(wb_adr_i[1:0]) != 2'h0 || $past(wb_adr_i) > OFS_SUMST)
    else $error("error answer on a mapped address");
  irq_rise_a: assert property ($rose(irq_o) |->
    $past(evt | tx_taken_i | (wb_cyc_i & wb_stb_i & wb_we_i)))
    else $error("interrupt rose with no event or write");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(wb_cyc_i & wb_stb_i))
    else $error("interrupt fell with no register access");
  match_valid_a: assert property (addr_match_o |-> addr_valid_i)
    else $error("address match outside an address pulse");
  tx_write_a: assert property ($changed(tx_byte_o) |->
    $past(req & wb_we_i) && $past(wb_adr_i) == OFS_DATA
    && tx_byte_o == $past(wb_dat_i[7:0]))
    else $error("send byte changed without a data write");
endmodule
bind i2ctis_top i2ctis_checker i2ctis_checker_inst (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
  .wb_err_o, .bus_start_i, .bus_stop_i, .addr_valid_i, .rx_valid_i,
  .tx_taken_i, .tx_byte_o, .addr_match_o, .irq_o);

// ==== bench/i2ctis_master_model.sv ====
// model: shift engine reporting what an i2c bus master does
// assumes: bench calls pulse between clock edges
`timescale 1ns/1ps
// ********
// events
// ********
module i2ctis_master_model (
  input  wire logic       clk_i,
  output logic [4:0]      kind_o,
  output logic [7:0]      byte_o
);
  initial kind_o = 5'h00;
  initial byte_o = 8'h00;
  // kind: taken, stop, start, address, rx; one-cycle pulse
  // stale bytes are inverted so nothing can lean on them
  task automatic pulse(input logic [4:0] k, input logic [7:0] b);
    @(posedge clk_i);
    kind_o <= k;
    byte_o <= b;
    @(posedge clk_i);
    kind_o <= 5'h00;
    byte_o <= ~b;
    #1;
  endtask
endmodule

// ==== bench/test_i2c_target_irq_status.sv ====
// bench: random and corner traffic through the target block
// assumes: package, design, checker and model compiled first
`timescale 1ns/1ps
// ********
// bench
// ********
module test_i2c_target_irq_status;
  import i2ctis_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, err, ae;
  logic [7:0] adr = 8'h00, tb, d1, d2;
  logic [31:0] wd = 32'h0, dat_o, rd;
  logic [4:0] k;
  logic [7:0] b;
  logic [6:0] pa, sa;
  logic [2:0] m, c;
  logic am, irq;
  int failures = 0, n_tests = 0, cnt = 0;
  i2ctis_top i2ctis_top_inst (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .bus_start_i(k[2]), .bus_stop_i(k[3]), .addr_valid_i(k[1]),
    .addr_byte_i(b[6:0]), .addr_rnw_i(b[7]), .rx_valid_i(k[0]),
    .rx_byte_i(b), .tx_taken_i(k[4]), .tx_byte_o(tb),
    .addr_match_o(am), .irq_o(irq));
  i2ctis_master_model i2ctis_master_model_inst (.clk_i, .kind_o(k),
    .byte_o(b));
  always #2.5 clk_i = ~clk_i;
  // every address pulse: match only on an own address while enabled
  always @(posedge clk_i) if (!rst_i && k[1] === 1'b1)
    chk("match", am, b[6:0] == pa || b[6:0] == sa);
  always @(posedge clk_i) if (++cnt == 5000) begin
    failures++;
    summarize();
  end
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && err !== 1'b1 && t < 50);
    if (t == 50) failures++;
    rd = dat_o;
    ae = err;
    {cyc, stb} <= 2'b00;
    #1;
  endtask
  task automatic rc(input string s, input logic [7:0] a, logic [31:0] e);
    wb(0, a, 32'h0);
    chk(s, rd, e);
  endtask
  initial begin
    void'($urandom(43));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    rc("ctrl", OFS_CTRL, CTRL_RST);
    rc("imask", OFS_IMASK, {29'h0, IMASK_RST});
    rc("own", OFS_OWNADDR, OWNADDR_RST);
    rc("action", OFS_ACTION, 32'h0);
    wb(0, 8'h24, 32'h0);
    chk("unmapped", ae, 1);
    repeat (4) begin
      {pa, m, c, d1, d2} = $urandom;
      sa = pa ^ 7'h55;
      wb(1, OFS_OWNADDR, {16'h0, 1'b1, sa, 1'b0, pa});
      wb(1, OFS_CTRL, 32'h3);
      wb(1, OFS_IMASK, m);
      i2ctis_master_model_inst.pulse(5'h04, 8'h00);
      i2ctis_master_model_inst.pulse(5'h02, {1'b0, pa});
      rc("act", OFS_ACTION, ACTION_IDLE);
      // foreign address: no match, no action change, no data event
      i2ctis_master_model_inst.pulse(5'h02, {1'b1, pa ^ 7'h2A});
      i2ctis_master_model_inst.pulse(5'h01, d1);
      rc("act", OFS_ACTION, ACTION_FIRST_BYTE_IN);
      rc("data", OFS_DATA, d1);
      i2ctis_master_model_inst.pulse(5'h01, d2);
      rc("act", OFS_ACTION, ACTION_MASTER_WROTE);
      i2ctis_master_model_inst.pulse(5'h08, 8'h00);
      rc("sum", OFS_SUMST, 32'h1);
      chk("irq", irq, |m);
      wb(1, OFS_CTRL, 32'h7);
      rc("sum", OFS_SUMST, |m);
      wb(1, OFS_ICLR, c);
      chk("irq", irq, |(m & ~c));
      rc("msk", OFS_MSKST, m & ~c);
      rc("raw", OFS_RAWST, 32'h0);
      i2ctis_master_model_inst.pulse(5'h04, 8'h00);
      i2ctis_master_model_inst.pulse(5'h02, {1'b1, sa});
      rc("act", OFS_ACTION, {27'h0, 3'h4, ACTION_MASTER_READS});
      wb(1, OFS_DATA, d2 ^ d1);
      chk("tx", tb, d2 ^ d1);
      i2ctis_master_model_inst.pulse(5'h10, 8'h00);
      i2ctis_master_model_inst.pulse(5'h08, 8'h00);
      wb(1, OFS_CTRL, 32'h1);
      wb(1, OFS_IMASK, 32'h7);
      chk("irq off", irq, 0);
      rc("raw", OFS_RAWST, 32'h7);
    end
    summarize();
  end
endmodule
